// ### dv/root_hub_port_change_asserts.sv
// concurrent checks on the root hub port change block ports
`timescale 1ns/10ps
`default_nettype none
module root_hub_port_change_asserts #(
	parameter int RESET_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire logic devicePresentPin,
	input wire logic lowSpeedPin,
	input wire logic transferBusy,
	input wire logic fixedDevice,
	input wire logic portPowerOn,
	input wire logic portResetting,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	int rstCnt;
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rstCnt <= 0;
		else
			rstCnt <= portResetting ? rstCnt + 1 : 0;
	end
	////////////////////////////////////////////////////////////////
	sequence s_wr;
		avsWrite && !avsWaitRequest && avsAddress == 4'h0 && avsByteEnable[1];
	endsequence
	property p_waitAck;
		(avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
	endproperty
	a_waitAck: assert property (p_waitAck) else $error("access not answered next cycle");
	property p_waitOne;
		!avsWaitRequest |=> avsWaitRequest;
	endproperty
	a_waitOne: assert property (p_waitOne) else $error("waitrequest low too long");
	property p_unmapped;
		avsRead && !avsWaitRequest && avsAddress > 4'h3 |-> avsReadData == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_pwrOn;
		s_wr ##0 (avsWriteData[8] && !avsWriteData[9] && !transferBusy) |=> portPowerOn;
	endproperty
	a_pwrOn: assert property (p_pwrOn) else $error("power on write lost");
	property p_pwrOff;
		s_wr ##0 (avsWriteData[9] && !avsWriteData[8] && !transferBusy) |=> ##[0:1] !portPowerOn;
	endproperty
	a_pwrOff: assert property (p_pwrOff) else $error("power off write lost");
	property p_busyHold;
		transferBusy |=> $stable(portPowerOn);
	endproperty
	a_busyHold: assert property (p_busyHold) else $error("power changed during transfer");
	property p_irqFall;
		$fell(irq) |-> $past(avsWrite, 2) || $past(avsWrite, 3);
	endproperty
	a_irqFall: assert property (p_irqFall) else $error("irq cleared without write");
	property p_speed;
		avsRead && !avsWaitRequest && avsAddress == 4'h0 && devicePresentPin && !fixedDevice
			&& $past(devicePresentPin, 6) && lowSpeedPin == $past(lowSpeedPin, 6)
			|-> avsReadData[9] == lowSpeedPin;
	endproperty
	a_speed: assert property (p_speed) else $error("speed bit wrong");
	property p_rstLen;
		$fell(portResetting) |-> rstCnt + 3 >= RESET_CYCLES && rstCnt <= RESET_CYCLES + 3;
	endproperty
	a_rstLen: assert property (p_rstLen) else $error("port reset length wrong");
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the root hub port change block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int RS = 20;
	localparam int RC = 20;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] avsAddress = 4'h0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0;
	logic [3:0] avsByteEnable = 4'hF;
	logic hwDisablePin = 1'b0;
	logic transferBusy = 1'b0;
	logic fixedDevice = 1'b0;
	logic rootHubReset = 1'b0;
	logic att = 1'b0;
	logic ls = 1'b0;
	logic wake = 1'b0;
	logic [31:0] rdv;
	wire [31:0] avsReadData;
	wire avsWaitRequest, devicePresentPin, lowSpeedPin, resumeDonePin;
	wire portPowerOn, portEnabled, portSuspended, portResetting, irq;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	root_hub_port_change #(.RESYNC_CYCLES(RS), .RESET_CYCLES(RC)) DUT (.clk_sys, .arst_n, .avsAddress,
		.avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .devicePresentPin,
		.lowSpeedPin, .hwDisablePin, .resumeDonePin, .transferBusy, .fixedDevice, .rootHubReset, .portPowerOn,
		.portEnabled, .portSuspended, .portResetting, .irq);
	usb_device_model dev (.clk_sys, .attach(att), .lowSpeed(ls), .wake, .devicePresentPin, .lowSpeedPin,
		.resumeDonePin);
	always #10 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic chk(input logic ok);
		compares++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("[FAIL] %0t check %0d mismatch", $time, compares);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avsAddress <= a;
		avsWriteData <= d;
		avsRead <= ~wr;
		avsWrite <= wr;
		do
			@(posedge clk_sys);
		while (avsWaitRequest !== 1'b0);
		rdv = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk((rdv & m) === e);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		w(16);
		arst_n <= 1'b1;
		w(1);
		rd(4'h0, 32'hFFFFFDFF, 32'h0);
		bus(1'b1, 4'h7, 32'hFFFFFFFF);
		rd(4'h7, 32'hFFFFFFFF, 32'h0);
		$display("test 1 done");
		bus(1'b1, 4'h2, 32'h1);
		rd(4'h2, 32'hFFFFFFFF, 32'h1);
		bus(1'b1, 4'h0, 32'h10);
		rd(4'h0, 32'h00010010, 32'h00010000);
		rd(4'h1, 32'hFFFFFFFF, 32'h1);
		w(2);
		chk(irq === 1'b1);
		bus(1'b1, 4'h2, 32'h0);
		w(2);
		chk(irq === 1'b0);
		bus(1'b1, 4'h2, 32'h1);
		bus(1'b1, 4'h0, 32'h0);
		rd(4'h0, 32'h00010000, 32'h00010000);
		bus(1'b1, 4'h1, 32'h1);
		rd(4'h1, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, 4'h0, 32'h00010000);
		w(2);
		chk(irq === 1'b0);
		rd(4'h0, 32'h00010000, 32'h0);
		$display("test 2 done");
		bus(1'b1, 4'h0, 32'h100);
		chk(portPowerOn === 1'b1);
		att <= 1'b1;
		ls <= 1'b1;
		w(8);
		rd(4'h0, 32'h00010201, 32'h00010201);
		bus(1'b1, 4'h0, 32'h00010002);
		chk(portEnabled === 1'b1);
		rd(4'h0, 32'h00020000, 32'h0);
		hwDisablePin <= 1'b1;
		w(6);
		hwDisablePin <= 1'b0;
		chk(portEnabled === 1'b0);
		rd(4'h0, 32'h00020000, 32'h00020000);
		bus(1'b1, 4'h0, 32'h00020002);
		$display("test 3 done");
		bus(1'b1, 4'h0, 32'h4);
		chk(portSuspended === 1'b1);
		wake <= 1'b1;
		w(4);
		wake <= 1'b0;
		rd(4'h0, 32'h00040000, 32'h0);
		w(RS + 4);
		rd(4'h0, 32'h00040000, 32'h00040000);
		bus(1'b1, 4'h0, 32'h10);
		chk(portResetting === 1'b1);
		w(RC + 6);
		rd(4'h0, 32'h00140010, 32'h00100000);
		bus(1'b1, 4'h0, 32'h00130000);
		$display("test 4 done");
		fixedDevice <= 1'b1;
		att <= 1'b0;
		w(8);
		att <= 1'b1;
		w(8);
		rd(4'h0, 32'h00010000, 32'h0);
		rootHubReset <= 1'b1;
		w(1);
		rootHubReset <= 1'b0;
		w(6);
		rd(4'h0, 32'h00010000, 32'h00010000);
		$display("test 5 done");
		transferBusy <= 1'b1;
		bus(1'b1, 4'h0, 32'h200);
		rd(4'h3, 32'hFFFFFFFF, 32'h1);
		w(3);
		chk(portPowerOn === 1'b1);
		transferBusy <= 1'b0;
		w(3);
		chk(portPowerOn === 1'b0);
		transferBusy <= 1'b1;
		bus(1'b1, 4'h0, 32'h100);
		w(3);
		chk(portPowerOn === 1'b0);
		transferBusy <= 1'b0;
		w(3);
		chk(portPowerOn === 1'b1);
		bus(1'b1, 4'h0, 32'h0);
		chk(portPowerOn === 1'b1);
		bus(1'b1, 4'h0, 32'h200);
		chk(portPowerOn === 1'b0);
		$display("test 6 done");
		complete_run();
	end
endmodule
bind root_hub_port_change root_hub_port_change_asserts #(.RESET_CYCLES(RESET_CYCLES)) chkr (.clk_sys, .arst_n,
	.avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest,
	.devicePresentPin, .lowSpeedPin, .transferBusy, .fixedDevice, .portPowerOn, .portResetting, .irq);
`default_nettype wire

// ### dv/usb_device_model.sv
// behavioural downstream device: attach, speed and resume signalling
`timescale 1ns/10ps
`default_nettype none
module usb_device_model (
	input wire logic clk_sys,
	input wire logic attach,
	input wire logic lowSpeed,
	input wire logic wake,
	output logic devicePresentPin,
	output logic lowSpeedPin,
	output logic resumeDonePin
);
	initial {devicePresentPin, lowSpeedPin, resumeDonePin} = 3'h0;
	always @(posedge clk_sys)
	begin
		devicePresentPin <= attach;
		lowSpeedPin <= attach ? lowSpeed : ~lowSpeedPin;
		resumeDonePin <= wake;
	end
endmodule
`default_nettype wire

// ### verilog/root_hub_port_change.v
// root hub port status/change register with change flags, power-off command and interrupt
// Behaviour
// RULE1 - suspend change set after resume resync completes
// RULE2 - suspend change cleared when reset change sets
// RULE3 - enable change set on hardware disable
// RULE4 - software enable writes leave enable change
// RULE5 - connect change set on attach or detach
// RULE6 - commands on disconnected port set connect change
// RULE7 - fixed device: connect change only after reset
// RULE8 - low speed bit reads device speed
// RULE9 - software trusts speed only while connected
// RULE10 - writing one at bit nine powers off
// RULE11 - change flags clear on writing one
// RULE12 - status writes wait for transaction end
// RULE13 - reset change set when reset period ends
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "root_hub_port_defines.vh"

module root_hub_port_change #(
	parameter RESYNC_CYCLES = `RESYNC_CYCLES,
	parameter RESET_CYCLES = `RESET_CYCLES
) (
	input wire clk_sys,
	input wire arst_n,
	input wire [3:0] avsAddress,
	input wire avsRead,
	input wire avsWrite,
	input wire [31:0] avsWriteData,
	input wire [3:0] avsByteEnable,
	output reg [31:0] avsReadData,
	output reg avsWaitRequest,
	input wire devicePresentPin,
	input wire lowSpeedPin,
	input wire hwDisablePin,
	input wire resumeDonePin,
	input wire transferBusy,
	input wire fixedDevice,
	input wire rootHubReset,
	output reg portPowerOn,
	output reg portEnabled,
	output reg portSuspended,
	output reg portResetting,
	output reg irq
);

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	// pin levels reach the logic two cycles late
	reg [3:0] syncA_reg;
	reg [3:0] syncB_reg;
	wire devicePresent = syncB_reg[0];
	wire lowSpeed = syncB_reg[1];
	wire hwDisable = syncB_reg[2];
	wire resumeDone = syncB_reg[3];

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncA_reg <= 4'h0;
			syncB_reg <= 4'h0;
		end
		else
		begin
			syncA_reg <= {resumeDonePin, hwDisablePin, lowSpeedPin, devicePresentPin};
			syncB_reg <= syncA_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, then the access completes
	// waitrequest idles high, so each access costs two cycles
	reg ackPending_reg;
	wire accessStart = (avsRead | avsWrite) & ~ackPending_reg;
	wire writeDone = avsWrite & ackPending_reg;
	wire readDone = avsRead & ackPending_reg;

	function wrOne;
		input [3:0] addr;
		input [3:0] want;
		input [31:0] data;
		input [3:0] be;
		input integer pos;
		begin
			wrOne = (addr == want) & data[pos] & be[pos / 8];
		end
	endfunction

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			ackPending_reg <= 1'b0;
		else
			ackPending_reg <= accessStart;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			avsWaitRequest <= 1'b1;
		else
			avsWaitRequest <= ~accessStart;
	end

	////////////////////////////////////////////////////////////////
	// port status commands, postponed while a transaction runs
	reg pendReset_reg;
	reg pendEnable_reg;
	reg pendSuspend_reg;
	reg pendPowerOff_reg;
	reg pendPowerOn_reg;
	wire cmdReset = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_RESETTING);
	wire cmdEnable = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_ENABLED);
	wire cmdSuspend = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_SUSPENDED);
	wire cmdPowerOn = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_POWERED);
	// RULE10 power off command
	wire cmdPowerOff = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_LOW_SPEED);
	// RULE12 hold until idle
	wire applyNow = ~transferBusy;
	wire doReset = applyNow & (cmdReset | pendReset_reg);
	wire doEnable = applyNow & (cmdEnable | pendEnable_reg);
	wire doSuspend = applyNow & (cmdSuspend | pendSuspend_reg);
	wire doPowerOff = applyNow & (cmdPowerOff | pendPowerOff_reg);
	// power on waits as well, since it changes port status
	wire doPowerOn = applyNow & (cmdPowerOn | pendPowerOn_reg);

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pendReset_reg <= 1'b0;
			pendEnable_reg <= 1'b0;
			pendSuspend_reg <= 1'b0;
			pendPowerOff_reg <= 1'b0;
			pendPowerOn_reg <= 1'b0;
		end
		else
		begin
			pendReset_reg <= transferBusy & (cmdReset | pendReset_reg);
			pendEnable_reg <= transferBusy & (cmdEnable | pendEnable_reg);
			pendSuspend_reg <= transferBusy & (cmdSuspend | pendSuspend_reg);
			pendPowerOff_reg <= transferBusy & (cmdPowerOff | pendPowerOff_reg);
			pendPowerOn_reg <= transferBusy & (cmdPowerOn | pendPowerOn_reg);
		end
	end

	////////////////////////////////////////////////////////////////
	// port reset timer and resume resync timer
	reg [31:0] resetCount_reg;
	reg [31:0] resyncCount_reg;
	reg resyncBusy_reg;
	reg resumeDonePrev_reg;
	wire resetEnds = portResetting & (resetCount_reg == 32'h00000001);
	wire resyncEnds = resyncBusy_reg & (resyncCount_reg == 32'h00000001);

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			portPowerOn <= 1'b0;
			portEnabled <= 1'b0;
			portSuspended <= 1'b0;
			portResetting <= 1'b0;
			resetCount_reg <= 32'h00000000;
			resyncCount_reg <= 32'h00000000;
			resyncBusy_reg <= 1'b0;
			resumeDonePrev_reg <= 1'b0;
		end
		else
		begin
			resumeDonePrev_reg <= resumeDone;
			if (doPowerOff)
				portPowerOn <= 1'b0;
			else if (doPowerOn)
				portPowerOn <= 1'b1;
			// a new reset command restarts the full period
			if (doReset & devicePresent & portPowerOn)
			begin
				portResetting <= 1'b1;
				resetCount_reg <= RESET_CYCLES;
			end
			else if (portResetting)
				resetCount_reg <= resetCount_reg - 32'h00000001;
			if (resetEnds | ~devicePresent | doPowerOff)
				portResetting <= 1'b0;
			// RULE4 software enable path
			if (hwDisable | ~devicePresent | doPowerOff)
				portEnabled <= 1'b0;
			else if (resetEnds | (doEnable & devicePresent))
				portEnabled <= 1'b1;
			if (resumeDone & ~resumeDonePrev_reg & portSuspended)
			begin
				resyncBusy_reg <= 1'b1;
				resyncCount_reg <= RESYNC_CYCLES;
			end
			else if (resyncEnds)
				resyncBusy_reg <= 1'b0;
			else if (resyncBusy_reg)
				resyncCount_reg <= resyncCount_reg - 32'h00000001;
			if (resyncEnds | ~devicePresent | doPowerOff | resetEnds)
				portSuspended <= 1'b0;
			else if (doSuspend & devicePresent & portEnabled)
				portSuspended <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// change flags, set wins over software clear
	reg connectChg_reg;
	reg enableChg_reg;
	reg suspendChg_reg;
	reg resetChg_reg;
	reg presentPrev_reg;
	reg hubResetSeen_reg;
	wire clrConnect = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_CONNECT_CHG);
	wire clrEnable = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_ENABLE_CHG);
	wire clrSuspend = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_SUSPEND_CHG);
	wire clrReset = writeDone & wrOne(avsAddress, `ADDR_PORT_STATUS, avsWriteData, avsByteEnable, `BIT_RESET_CHG);
	// fixed device: edges ignored, one report per hub reset
	// RULE5 attach or detach
	wire edgeSeen = (devicePresent != presentPrev_reg) & ~fixedDevice;
	// RULE7 fixed device report
	wire fixedReport = fixedDevice & hubResetSeen_reg & devicePresent;
	// RULE6 commands while disconnected
	wire staleCmd = (doReset | doEnable | doSuspend) & ~devicePresent;
	wire setConnect = edgeSeen | fixedReport | staleCmd;
	// RULE3 hardware disable or disconnect while enabled
	wire setEnable = portEnabled & (hwDisable | ~devicePresent);
	// RULE1 after resync delay
	wire setSuspend = resyncEnds;
	// RULE13 reset period end
	wire setReset = resetEnds;

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			connectChg_reg <= 1'b0;
			enableChg_reg <= 1'b0;
			suspendChg_reg <= 1'b0;
			resetChg_reg <= 1'b0;
			presentPrev_reg <= 1'b0;
			hubResetSeen_reg <= 1'b0;
		end
		else
		begin
			presentPrev_reg <= devicePresent;
			if (rootHubReset)
				hubResetSeen_reg <= 1'b1;
			else if (fixedReport)
				hubResetSeen_reg <= 1'b0;
			// RULE11 write one clears
			connectChg_reg <= setConnect | (connectChg_reg & ~clrConnect);
			enableChg_reg <= setEnable | (enableChg_reg & ~clrEnable);
			resetChg_reg <= setReset | (resetChg_reg & ~clrReset);
			// RULE2 cleared by reset change
			if (setReset)
				suspendChg_reg <= 1'b0;
			else
				suspendChg_reg <= setSuspend | (suspendChg_reg & ~clrSuspend);
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt status and mask
	reg [`IRQ_WIDTH-1:0] irqStatus_reg;
	reg [`IRQ_WIDTH-1:0] irqMask_reg;
	wire [`IRQ_WIDTH-1:0] irqEvents = {setReset, setSuspend, setEnable, setConnect};
	wire [`IRQ_WIDTH-1:0] irqStatus_next;
	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1)
		begin : irqBit
			// set wins when an event meets its own clear
			assign irqStatus_next[gi] = irqEvents[gi] |
				(irqStatus_reg[gi] & ~(writeDone & wrOne(avsAddress, `ADDR_IRQ_STATUS, avsWriteData, avsByteEnable, gi)));
		end
	endgenerate

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			irqStatus_reg <= 4'h0;
		else
			irqStatus_reg <= irqStatus_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irqMask_reg <= 4'h0;
			irq <= 1'b0;
		end
		else
		begin
			if (writeDone & (avsAddress == `ADDR_IRQ_MASK) & avsByteEnable[0])
				irqMask_reg <= avsWriteData[`IRQ_WIDTH-1:0];
			// registered, so irq trails status and mask by a cycle
			irq <= |(irqStatus_reg & irqMask_reg);
		end
	end

	////////////////////////////////////////////////////////////////
	// read data
	// unmapped indices read zero and ignore writes
	reg [31:0] readMux;
	always @*
	begin
		readMux = 32'h00000000;
		case (avsAddress)
			`ADDR_PORT_STATUS:
			begin
				readMux[`BIT_CONNECTED] = devicePresent;
				readMux[`BIT_ENABLED] = portEnabled;
				readMux[`BIT_SUSPENDED] = portSuspended;
				readMux[`BIT_RESETTING] = portResetting;
				readMux[`BIT_POWERED] = portPowerOn;
				// RULE8 speed on read
				readMux[`BIT_LOW_SPEED] = lowSpeed;
				readMux[`BIT_CONNECT_CHG] = connectChg_reg;
				readMux[`BIT_ENABLE_CHG] = enableChg_reg;
				readMux[`BIT_SUSPEND_CHG] = suspendChg_reg;
				readMux[`BIT_RESET_CHG] = resetChg_reg;
			end
			`ADDR_IRQ_STATUS: readMux[`IRQ_WIDTH-1:0] = irqStatus_reg;
			`ADDR_IRQ_MASK: readMux[`IRQ_WIDTH-1:0] = irqMask_reg;
			`ADDR_PORT_CTRL: readMux[0] = transferBusy;
			default: readMux = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			avsReadData <= 32'h00000000;
		else if (accessStart & avsRead)
			avsReadData <= readMux;
	end

endmodule
`default_nettype wire

// ### verilog/root_hub_port_defines.vh
// register map, field positions and timing counts for the root hub port change block
`ifndef ROOT_HUB_PORT_DEFINES_VH
`define ROOT_HUB_PORT_DEFINES_VH

`define ADDR_PORT_STATUS 4'h0
`define ADDR_IRQ_STATUS 4'h1
`define ADDR_IRQ_MASK 4'h2
`define ADDR_PORT_CTRL 4'h3

`define BIT_CONNECTED 0
`define BIT_ENABLED 1
`define BIT_SUSPENDED 2
`define BIT_RESETTING 4
`define BIT_POWERED 8
`define BIT_LOW_SPEED 9
`define BIT_CONNECT_CHG 16
`define BIT_ENABLE_CHG 17
`define BIT_SUSPEND_CHG 18
`define BIT_RESET_CHG 20

`define IRQ_CONNECT 0
`define IRQ_ENABLE 1
`define IRQ_SUSPEND 2
`define IRQ_RESET 3
`define IRQ_WIDTH 4

`define CLK_MHZ 50
`define RESYNC_MS 3
`define RESYNC_CYCLES (`RESYNC_MS * 1000 * `CLK_MHZ)
`define RESET_MS 10
`define RESET_CYCLES (`RESET_MS * 1000 * `CLK_MHZ)

`endif
